// >>> rtl/rbms_pkg.sv
// package of constants and carrier types for the reset, boot mode and memory select block
// assumes a single processor clock domain; no other file is required
package rbms_pkg;
    // mode pin bundle as sampled during reset
    typedef struct packed {
        logic ackStyle;
        logic memMode;
        logic bootOff;
        logic bootSrc;
    } rbms_mode_s;

    // program overlay decode result
    typedef struct packed {
        logic external;
        logic upperBit;
        logic [12:0] lowAddr;
    } rbms_ovl_s;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_BYTE_BOOT,
        ST_HOST_BOOT,
        ST_RUN
    } rbms_state_e;

    // apb register offsets (byte addresses)
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_OVERLAY = 12'h008;
    localparam logic [11:0] OFS_DATA_MEMORY_WAIT_STATES = 12'h00c;
    localparam logic [11:0] OFS_MODE_STATUS_REGISTER = 12'h010;

    // field positions
    localparam int CTL_BUS_REQ = 0;
    localparam int CTL_WORD_LOADED = 1;
    localparam int CTL_PM0_WRITTEN = 2;

    // reset values
    localparam logic [2:0] RST_OVERLAY = 3'h0;
    localparam logic [2:0] RST_DATA_MEMORY_WAIT_STATES = 3'h0;
    localparam logic [6:0] RST_MODE_STATUS_REGISTER = 7'h00;
    localparam logic [11:0] RST_IMASK = 12'h000;
    localparam logic [3:0] STACK_EMPTY = 4'h0;

    // memory figures
    localparam int BOOT_WORDS = 32;
    localparam int DM_USER_WORDS = 16352;
    localparam int DM_CTRL_REGS = 32;
    localparam int PM_WIDTH = 24;
    localparam int HOST_BUS_WIDTH = 16;
    localparam int OVL_WORDS = 8192;
    localparam logic [13:0] OVL_WIN_LO = 14'h2000;
    localparam logic [13:0] OVL_WIN_HI = 14'h3fff;
    localparam logic [13:0] BOOT_START_PC = 14'h0000;
    localparam logic [13:0] EXT_START_PC = 14'h0000;

    // power-up hold on the input clock; board side obligation
    localparam int PWRUP_INPUT_CLOCK_CYCLES = 2000;
endpackage

// >>> rtl/rbms_overlay_decode.sv
// program overlay selector decode
// assumes combinational use by the main block on the same clock
module rbms_overlay_decode (
    input wire logic [2:0] overlaySel, // program_overlay_select value
    input wire logic [13:0] addr, // program address
    input wire logic hostMode, // host memory mode
    output rbms_pkg::rbms_ovl_s ovl // decode result
);
    logic inWindow;
    assign inWindow = (addr >= rbms_pkg::OVL_WIN_LO) && (addr <= rbms_pkg::OVL_WIN_HI);

    always_comb begin
        ovl = '0;
        if (inWindow && (overlaySel == 3'h1)) begin
            ovl.external = 1'b1;
            ovl.upperBit = 1'b0;
            ovl.lowAddr = addr[12:0];
        end else if (inWindow && (overlaySel == 3'h2)) begin
            ovl.external = 1'b1;
            ovl.upperBit = 1'b1;
            ovl.lowAddr = addr[12:0];
        end
        // host mode: only the single low address line leaves the chip
        if (hostMode) begin
            ovl.upperBit = 1'b0;
            ovl.lowAddr = {12'h000, addr[0]};
        end
    end
endmodule

// >>> rtl/rbms_wait_gen.sv
// data memory wait state stretcher
// assumes a one-cycle access request pulse from the main block
module rbms_wait_gen #(
    parameter int WAIT_W = 3 // width of the wait state count
) (
    input wire logic clk_sys, // processor clock
    input wire logic rstN, // synchronised reset, active low
    input wire logic start, // access request pulse
    input wire logic external, // access targets external memory
    input wire logic [WAIT_W-1:0] waitStates, // programmed wait states
    output logic busy, // access still stretched
    output logic done // access complete pulse
);
    logic [WAIT_W-1:0] count;
    logic active;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            count <= '0;
            active <= 1'b0;
        end else if (start && external && (waitStates != '0)) begin
            count <= waitStates;
            active <= 1'b1;
        end else if (active) begin
            count <= count - 1'b1;
            if (count == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
                active <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            done <= 1'b0;
        end else begin
            // internal or zero-wait accesses finish in the next cycle
            done <= (start && (!external || (waitStates == '0)))
                || (active && (count == {{(WAIT_W-1){1'b0}}, 1'b1}));
        end
    end

    assign busy = active;
endmodule

// >>> rtl/rbms_top.sv
// reset sequencing, boot mode capture and memory select for the processor core
// assumes mode pins are asynchronous; boot progress arrives as apb control writes on clk_sys
// Contract
// - later resets keep the clock running and need no stabilisation wait
// - reset empties stacks, masks all interrupts, clears mode status
// - boot runs at release only without pending bus request and boot selected
// - after boot, first fetch is from on-chip program address zero
// - mode pins are sampled only while reset is low
// - memory-mode pin 0 selects full mode, 1 selects host mode
// - boot-enable pin 0 enables auto boot, 1 disables it
// - boot-source pin 0 selects byte dma, 1 selects host dma
// - byte boot loads 32 words and holds execution until all loaded
// - full mode without boot starts at external address zero, no dma wait
// - host boot holds execution until internal program address zero written
// - host mode ack is driven when style pin 0, open-source when 1
// - overlay 1 and 2 map window with upper bit 0 and 1; else internal
// - host mode overlay uses one address line; no external execution
// - internal data memory 16352 words plus 32 registers, single cycle
// - external data accesses stretched by programmed wait states
// - full mode program memory 24 bits with two 8k external overlays
//
// The register addresses and the APB slave port are this design's own decisions.
module rbms_top (
    input wire logic clk_sys, // processor clock
    input wire logic reset_n, // master reset, active low
    input wire logic modeAPin, // boot source strap
    input wire logic modeBPin, // boot enable strap
    input wire logic modeDPin, // ack style strap
    input wire logic sharedFlagPinIn, // shared_flag_pin level, mode c strap
    output logic sharedFlagPinOut, // shared_flag_pin output value
    output logic sharedFlagPinOe, // shared_flag_pin output enable
    input wire logic hostAccessAckReq, // core wants to assert host_access_ack (active low pin)
    output logic hostAccessAckOut, // host_access_ack pin value
    output logic hostAccessAckOe, // host_access_ack output enable
    input wire logic [13:0] pmAddr, // program memory address
    output rbms_pkg::rbms_ovl_s pmOvl, // overlay decode result
    output logic pmExtExecAllowed, // external program execution possible
    input wire logic dmStart, // data memory access pulse
    input wire logic dmExternal, // data access targets external space
    output logic dmBusy, // data access stretched
    output logic dmDone, // data access complete pulse
    output logic coreRun, // execution enabled
    output logic [13:0] startPc, // first fetch address
    output logic startExternal, // first fetch from external memory
    output logic [11:0] imask, // interrupt mask
    output logic [3:0] stackPtr, // stack pointer
    output logic [6:0] modeStatus, // mode_status_register
    output logic bootByteDmaReq, // byte_memory_dma boot in progress
    output logic bootHostDma, // host_internal_dma boot in progress
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error
);
    logic rstMeta, rstN;
    logic [3:0] pinMeta, pinSync;
    rbms_pkg::rbms_mode_s sampled, mode;
    rbms_pkg::rbms_state_e state, next_state;
    logic busReq, wordLoaded, pm0Written;
    logic [5:0] bootCount;
    logic released;
    logic [2:0] overlaySel;
    logic [2:0] dwaitReg;
    logic [6:0] mstatReg;
    logic apbWr, apbRd, addrOk;
    logic busReqEvt, wordEvt, pm0Evt;

    // reset release through two flops; clock stays running across resets
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // pin synchronisers; no reset, so the straps are seen while reset is held
    always_ff @(posedge clk_sys) begin
        pinMeta <= {modeDPin, sharedFlagPinIn, modeBPin, modeAPin};
        pinSync <= pinMeta;
    end

    // straps tracked only while reset is held
    always_ff @(posedge clk_sys) begin
        if (!rstN) begin
            sampled.ackStyle <= pinSync[3];
            sampled.memMode <= pinSync[2];
            sampled.bootOff <= pinSync[1];
            sampled.bootSrc <= pinSync[0];
        end
    end

    // latch at release, hold until next reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode <= '0;
            released <= 1'b0;
        end else if (!rstN) begin
            released <= 1'b0;
        end else if (!released) begin
            mode <= sampled;
            released <= 1'b1;
        end
    end

    // the mode c strap shares the flag pin; the device never drives it during reset
    assign sharedFlagPinOut = 1'b0;
    assign sharedFlagPinOe = 1'b0;

    // host ack drive style
    always_comb begin
        hostAccessAckOut = !hostAccessAckReq;
        hostAccessAckOe = 1'b0;
        if (released && mode.memMode) begin
            if (!mode.ackStyle) begin
                hostAccessAckOe = 1'b1;
            end else begin
                // open-source: drive only the high level, pull-down gives low
                hostAccessAckOe = !hostAccessAckReq;
                hostAccessAckOut = 1'b1;
            end
        end
    end

    // boot sequencer
    always_comb begin
        next_state = state;
        case (state)
            rbms_pkg::ST_RESET: begin
                if (!released) begin
                    next_state = rbms_pkg::ST_RESET;
                end else if (busReq || mode.bootOff) begin
                    next_state = rbms_pkg::ST_RUN;
                end else if (mode.bootSrc) begin
                    next_state = rbms_pkg::ST_HOST_BOOT;
                end else begin
                    next_state = rbms_pkg::ST_BYTE_BOOT;
                end
            end
            rbms_pkg::ST_BYTE_BOOT: begin
                if (bootCount == 6'(rbms_pkg::BOOT_WORDS)) begin
                    next_state = rbms_pkg::ST_RUN;
                end
            end
            rbms_pkg::ST_HOST_BOOT: begin
                if (pm0Written) begin
                    next_state = rbms_pkg::ST_RUN;
                end
            end
            rbms_pkg::ST_RUN: begin
                next_state = rbms_pkg::ST_RUN;
            end
            default: begin
                next_state = rbms_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= rbms_pkg::ST_RESET;
        end else if (!rstN) begin
            state <= rbms_pkg::ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // boot word counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bootCount <= 6'h00;
        end else if (state != rbms_pkg::ST_BYTE_BOOT) begin
            bootCount <= 6'h00;
        end else if (wordLoaded && (bootCount != 6'(rbms_pkg::BOOT_WORDS))) begin
            bootCount <= bootCount + 6'h01;
        end
    end

    // start address chosen at release
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            startPc <= 14'h0000;
            startExternal <= 1'b0;
        end else if (state == rbms_pkg::ST_RESET && released) begin
            if (next_state == rbms_pkg::ST_RUN && !mode.memMode && mode.bootOff) begin
                startPc <= rbms_pkg::EXT_START_PC;
                startExternal <= 1'b1;
            end else begin
                startPc <= rbms_pkg::BOOT_START_PC;
                startExternal <= 1'b0;
            end
        end
    end

    assign coreRun = (state == rbms_pkg::ST_RUN);
    assign bootByteDmaReq = (state == rbms_pkg::ST_BYTE_BOOT);
    assign bootHostDma = (state == rbms_pkg::ST_HOST_BOOT);

    // master reset state of the core
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            imask <= rbms_pkg::RST_IMASK;
            stackPtr <= rbms_pkg::STACK_EMPTY;
        end else if (!rstN) begin
            imask <= rbms_pkg::RST_IMASK;
            stackPtr <= rbms_pkg::STACK_EMPTY;
        end
    end

    // apb slave, zero wait states
    assign pready = 1'b1;
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && !pwrite;

    always_comb begin
        addrOk = 1'b0;
        if (paddr == rbms_pkg::OFS_CONTROL) begin
            addrOk = 1'b1;
        end else if (paddr == rbms_pkg::OFS_STATUS) begin
            addrOk = 1'b1;
        end else if (paddr == rbms_pkg::OFS_OVERLAY) begin
            addrOk = 1'b1;
        end else if (paddr == rbms_pkg::OFS_DATA_MEMORY_WAIT_STATES) begin
            addrOk = 1'b1;
        end else if (paddr == rbms_pkg::OFS_MODE_STATUS_REGISTER) begin
            addrOk = 1'b1;
        end
    end
    assign pslverr = psel && penable && !addrOk;

    // control strobes from software, one cycle each
    assign busReqEvt = apbWr && (paddr == rbms_pkg::OFS_CONTROL);
    assign wordEvt = busReqEvt && pwdata[rbms_pkg::CTL_WORD_LOADED];
    assign pm0Evt = busReqEvt && pwdata[rbms_pkg::CTL_PM0_WRITTEN];
    assign wordLoaded = wordEvt;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busReq <= 1'b0;
        end else if (busReqEvt) begin
            busReq <= pwdata[rbms_pkg::CTL_BUS_REQ];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pm0Written <= 1'b0;
        end else if (!rstN) begin
            pm0Written <= 1'b0;
        end else if (pm0Evt) begin
            pm0Written <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            overlaySel <= rbms_pkg::RST_OVERLAY;
            dwaitReg <= rbms_pkg::RST_DATA_MEMORY_WAIT_STATES;
        end else if (apbWr && (paddr == rbms_pkg::OFS_OVERLAY)) begin
            overlaySel <= pwdata[2:0];
        end else if (apbWr && (paddr == rbms_pkg::OFS_DATA_MEMORY_WAIT_STATES)) begin
            dwaitReg <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mstatReg <= rbms_pkg::RST_MODE_STATUS_REGISTER;
        end else if (!rstN) begin
            mstatReg <= rbms_pkg::RST_MODE_STATUS_REGISTER;
        end else if (apbWr && (paddr == rbms_pkg::OFS_MODE_STATUS_REGISTER)) begin
            mstatReg <= pwdata[6:0];
        end
    end
    assign modeStatus = mstatReg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (apbRd && !penable) begin
            if (paddr == rbms_pkg::OFS_CONTROL) begin
                prdata <= {31'h00000000, busReq};
            end else if (paddr == rbms_pkg::OFS_STATUS) begin
                prdata <= {16'h0000, 2'h0, bootCount, pm0Written, released,
                    mode.ackStyle, mode.memMode, mode.bootOff, mode.bootSrc,
                    coreRun, startExternal};
            end else if (paddr == rbms_pkg::OFS_OVERLAY) begin
                prdata <= {29'h00000000, overlaySel};
            end else if (paddr == rbms_pkg::OFS_DATA_MEMORY_WAIT_STATES) begin
                prdata <= {29'h00000000, dwaitReg};
            end else if (paddr == rbms_pkg::OFS_MODE_STATUS_REGISTER) begin
                prdata <= {25'h0000000, mstatReg};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // full mode gives a 24-bit program space with two external overlays
    assign pmExtExecAllowed = released && !mode.memMode;

    rbms_overlay_decode u_ovl (
        .overlaySel(overlaySel),
        .addr(pmAddr),
        .hostMode(mode.memMode),
        .ovl(pmOvl)
    );

    rbms_wait_gen #(
        .WAIT_W(3)
    ) u_wait (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .start(dmStart),
        .external(dmExternal),
        .waitStates(dwaitReg),
        .busy(dmBusy),
        .done(dmDone)
    );
endmodule

// >>> dv/rbms_top_monitor.sv
// checker for rbms_top
// assumes binding to rbms_top ports only
module rbms_top_monitor (
    input wire logic clk_sys, // clock
    input wire logic reset_n, // reset
    input wire logic hostAccessAckReq, // ack request
    input wire logic hostAccessAckOut, // ack value
    input wire logic hostAccessAckOe, // ack enable
    input wire logic [13:0] pmAddr, // pm address
    input wire rbms_pkg::rbms_ovl_s pmOvl, // overlay
    input wire logic pmExtExecAllowed, // ext exec
    input wire logic dmStart, // dm start
    input wire logic dmExternal, // dm external
    input wire logic dmBusy, // dm busy
    input wire logic dmDone, // dm done
    input wire logic coreRun, // running
    input wire logic [13:0] startPc, // first fetch
    input wire logic [11:0] imask, // int mask
    input wire logic [3:0] stackPtr, // stack
    input wire logic [6:0] modeStatus, // mode status
    input wire logic bootByteDmaReq, // byte boot
    input wire logic bootHostDma // host boot
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    mode_hold_a: assert property (coreRun && $past(coreRun) |-> $stable(pmExtExecAllowed))
        else $error("mode changed while running");
    ack_level_a: assert property (hostAccessAckOe |-> hostAccessAckOut == !hostAccessAckReq)
        else $error("ack level wrong");
    full_no_ack_a: assert property (pmExtExecAllowed |-> !hostAccessAckOe)
        else $error("ack driven in full mode");
    byte_hold_a: assert property (bootByteDmaReq |-> !coreRun && !bootHostDma)
        else $error("run during byte boot");
    host_hold_a: assert property (bootHostDma |-> !coreRun)
        else $error("run during host boot");
    boot_end_a: assert property ($fell(bootByteDmaReq) || $fell(bootHostDma) |-> coreRun)
        else $error("boot end without run");
    int_single_a: assert property (dmStart && !dmExternal |=> dmDone)
        else $error("internal access not single cycle");
    reset_clear_a: assert property ($rose(reset_n) |-> imask == rbms_pkg::RST_IMASK
        && stackPtr == rbms_pkg::STACK_EMPTY && modeStatus == rbms_pkg::RST_MODE_STATUS_REGISTER)
        else $error("reset state not clear");
    start_zero_a: assert property ($rose(coreRun) |-> startPc == rbms_pkg::BOOT_START_PC)
        else $error("start address not zero");
    ovl_low_a: assert property (pmOvl.external |-> pmOvl.lowAddr == pmAddr[12:0])
        else $error("overlay low address wrong");
    cover property ($fell(bootByteDmaReq));
    cover property ($fell(bootHostDma));
    cover property (dmStart && dmExternal ##1 dmBusy ##[1:20] dmDone);
endmodule

bind rbms_top rbms_top_monitor rbms_top_monitor_inst (.*);

// >>> dv/rbms_board_model.sv
// board: power-up reset, straps, flag driver, ack pull-down
// assumes requests come on clk_sys
module rbms_board_model #(
    parameter int PWRUP_CYCLES = rbms_pkg::PWRUP_INPUT_CLOCK_CYCLES, // power-up hold
    parameter int STRAP_HOLD = 4 // strap driver disable delay
) (
    input wire logic clk_sys, // clock
    input wire logic resetReq, // reset wanted
    input wire rbms_pkg::rbms_mode_s modeReq, // straps wanted
    input wire logic flagOut, // device flag value
    input wire logic flagOe, // device flag enable
    input wire logic ackOut, // device ack value
    input wire logic ackOe, // device ack enable
    output logic reset_n, // master reset
    output logic modeAPin, // boot source
    output logic modeBPin, // boot enable
    output logic modeDPin, // ack style
    output logic flagLevel, // flag wire
    output logic ackLevel // ack wire
);
    logic [15:0] upCount = 16'h0000;
    logic [3:0] relCount = 4'h0;
    logic stray = 1'b0;
    logic keep;
    initial reset_n = 1'b0;
    always @(posedge clk_sys) begin
        if (upCount < PWRUP_CYCLES) upCount <= upCount + 16'h0001;
        reset_n <= !(resetReq || upCount < PWRUP_CYCLES);
        relCount <= !reset_n ? 4'h0 : (keep ? relCount + 4'h1 : relCount);
        stray <= !stray;
    end
    // straps let go STRAP_HOLD cycles after reset is over; afterwards the lines wander
    assign keep = !reset_n || relCount < STRAP_HOLD;
    assign modeAPin = keep ? modeReq.bootSrc : stray;
    assign modeBPin = keep ? modeReq.bootOff : !stray;
    assign modeDPin = keep ? modeReq.ackStyle : stray;
    assign flagLevel = flagOe ? flagOut : (keep ? modeReq.memMode : stray);
    assign ackLevel = ackOe ? ackOut : 1'b0;
endmodule

// >>> dv/test_reset_boot_mode_memory_select.sv
// self-checking bench for rbms_top and board model
// assumes the checker binds itself
module test_reset_boot_mode_memory_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset_n, resetReq, modeAPin, modeBPin, modeDPin, flagLevel, ackLevel;
    logic flagOut, flagOe, hostAccessAckReq, hostAccessAckOut, hostAccessAckOe;
    logic pmExtExecAllowed, dmStart, dmExternal, dmBusy, dmDone, coreRun, startExternal;
    logic bootByteDmaReq, bootHostDma, psel, penable, pwrite, pready, pslverr;
    logic [13:0] pmAddr, startPc;
    logic [11:0] imask, paddr;
    logic [3:0] stackPtr;
    logic [6:0] modeStatus;
    logic [31:0] pwdata, prdata;
    rbms_pkg::rbms_ovl_s pmOvl;
    rbms_pkg::rbms_mode_s modeReq;
    int errors, samples_checked;

    rbms_top rbms_top_inst (.*, .sharedFlagPinIn(flagLevel), .sharedFlagPinOut(flagOut),
        .sharedFlagPinOe(flagOe));
    rbms_board_model #(.PWRUP_CYCLES(8)) rbms_board_model_inst (.clk_sys, .resetReq,
        .modeReq, .flagOut, .flagOe, .ackOut(hostAccessAckOut), .ackOe(hostAccessAckOe),
        .reset_n, .modeAPin, .modeBPin, .modeDPin, .flagLevel, .ackLevel);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task stop_test;
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task hang(input string m);
        errors++;
        $display("wrong value at %0t ns: %s timed out", $time, m);
        stop_test();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang("apb");
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp, input string m);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q & msk, exp, m);
        chk(e, 1'b0, m);
    endtask
    task do_reset(input rbms_pkg::rbms_mode_s m);
        int n;
        @(posedge clk_sys);
        modeReq <= m; resetReq <= 1'b1;
        repeat (8) @(posedge clk_sys);
        resetReq <= 1'b0;
        n = 0;
        while (reset_n !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20) hang("reset");
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task wait_run;
        int n;
        n = 0;
        while (coreRun !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 8) hang("run");
    endtask

    task byte_boot;
        do_reset(4'b0000);
        chk({imask, stackPtr, modeStatus}, 32'h0, "reset state");
        chk({coreRun, bootByteDmaReq, bootHostDma, pmExtExecAllowed}, 32'h5, "byte");
        repeat (31) wr(rbms_pkg::OFS_CONTROL, 32'h2);
        @(negedge clk_sys);
        chk(coreRun, 1'b0, "31 words");
        wr(rbms_pkg::OFS_CONTROL, 32'h2);
        wait_run();
        chk({startExternal, startPc}, 32'h0, "byte start");
        rdc(rbms_pkg::OFS_STATUS, 32'hff, 32'h42, "byte status");
    endtask
    task no_boot_dm;
        int n, ws;
        do_reset(4'b0010);
        wait_run();
        chk({startExternal, startPc, bootByteDmaReq, bootHostDma}, 32'h10000, "ext");
        rdc(rbms_pkg::OFS_STATUS, 32'hff, 32'h4b, "no boot status");
        for (int w = 0; w < 9; w += 3) begin
            ws = (w == 6) ? 7 : w;
            wr(rbms_pkg::OFS_DATA_MEMORY_WAIT_STATES, ws);
            for (int x = 0; x < 2; x++) begin
                @(posedge clk_sys);
                dmStart <= 1'b1; dmExternal <= x[0];
                @(posedge clk_sys);
                dmStart <= 1'b0;
                n = 0;
                do begin
                    @(negedge clk_sys);
                    n++;
                end while (dmDone !== 1'b1 && n < 20);
                chk(n, (x == 0 || ws == 0) ? 1 : ws + 1, "dm access");
            end
        end
    endtask
    task overlay_map;
        for (int v = 0; v < 6; v++) begin
            wr(rbms_pkg::OFS_OVERLAY, v);
            pmAddr <= 14'h2abc;
            @(negedge clk_sys);
            if (v == 1 || v == 2) chk(pmOvl, {1'b1, v == 2, 13'h0abc}, "ovl ext");
            else if (v != 3) chk(pmOvl.external, 1'b0, "ovl int");
        end
    endtask
    task host_boots;
        do_reset(4'b1101);
        chk({coreRun, bootByteDmaReq, bootHostDma, pmExtExecAllowed}, 32'h2, "host");
        wr(rbms_pkg::OFS_CONTROL, 32'h2);
        hostAccessAckReq <= 1'b1;
        @(negedge clk_sys);
        chk({coreRun, hostAccessAckOe, ackLevel}, 32'h0, "open ack low");
        @(posedge clk_sys);
        hostAccessAckReq <= 1'b0;
        @(negedge clk_sys);
        chk({hostAccessAckOe, hostAccessAckOut}, 32'h3, "open ack high");
        wr(rbms_pkg::OFS_CONTROL, 32'h4);
        wait_run();
        chk({startExternal, pmExtExecAllowed}, 32'h0, "host start");
        rdc(rbms_pkg::OFS_STATUS, 32'hff, 32'hf6, "host status");
        do_reset(4'b0100);
        @(posedge clk_sys);
        hostAccessAckReq <= 1'b1;
        @(negedge clk_sys);
        chk({bootByteDmaReq, hostAccessAckOe, hostAccessAckOut}, 32'h6, "driven ack");
        @(posedge clk_sys);
        hostAccessAckReq <= 1'b0;
    endtask
    task regs_reset;
        logic [31:0] q;
        logic e;
        wr(rbms_pkg::OFS_MODE_STATUS_REGISTER, 32'h55);
        rdc(rbms_pkg::OFS_MODE_STATUS_REGISTER, 32'h7f, 32'h55, "mode_status_register");
        apb(1'b0, 12'h01c, 32'h0, q, e);
        chk(q, 32'h0, "unmapped data");
        chk(e, 1'b1, "unmapped error");
        do_reset(4'b0010);
        rdc(rbms_pkg::OFS_MODE_STATUS_REGISTER, 32'h7f, 32'h0, "mode_status_register clear");
        chk(modeStatus, 32'h0, "mode_status_register port");
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        hang("run");
    end
    initial begin
        errors = 0; samples_checked = 0;
        resetReq = 1'b1; modeReq = 4'b0000;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        dmStart = 1'b0; dmExternal = 1'b0; hostAccessAckReq = 1'b0; pmAddr = 14'h0000;
        byte_boot();
        no_boot_dm();
        overlay_map();
        regs_reset();
        host_boots();
        stop_test();
    end
endmodule
